/* hw/sut_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the serial unit
// Assumes: Avalon-MM word addressing, 32-bit data, one register per word
// Notes:   Included by the design and the testbench
`ifndef SUT_DEFS_SVH
`define SUT_DEFS_SVH

// ============================================================
// Register word addresses
`define SUT_ADDR_CTRL1   3'h0
`define SUT_ADDR_CTRL2   3'h1
`define SUT_ADDR_DIV     3'h2
`define SUT_ADDR_STATUS  3'h3
`define SUT_ADDR_TXDATA  3'h4

// ============================================================
// Control register one fields
`define SUT_C1_UNIT_EN   7
`define SUT_C1_WORD_LEN  6
`define SUT_C1_PAR_EN    5
`define SUT_C1_PAR_TYPE  4
`define SUT_C1_STOP_CNT  3
`define SUT_C1_NINTH_TX  2
`define SUT_C1_RESET     8'h00

// ============================================================
// Control register two fields
`define SUT_C2_TX_EN     7
`define SUT_C2_RX_EN     6
`define SUT_C2_BAUD_HI   5
`define SUT_C2_BREAK     4
`define SUT_C2_ADDR_EN   3
`define SUT_C2_TX_EMPTY_IRQ_ENABLE      0
`define SUT_C2_RESET     8'h00

// ============================================================
// Status register fields
`define SUT_ST_PARITY_ERR_FLAG      7
`define SUT_ST_NOISE     6
`define SUT_ST_FRAME     5
`define SUT_ST_OVERRUN   4
`define SUT_ST_RX_QUIET  3
`define SUT_ST_RX_AVAIL  2
`define SUT_ST_TX_DONE   1
`define SUT_ST_TX_EMPTY  0

// ============================================================
// Baud divisor and timing
`define SUT_DIV_RESET    8'h00
`define SUT_PRE_LOW      8'h3f
`define SUT_PRE_HIGH     8'h0f
`define SUT_BREAK_BITS   4'hd

`endif

/* hw/sut_pkg.sv */
// Purpose: Types shared by the serial unit transmitter
// Assumes: sut_defs.svh constants
// Notes:   Types only
package sut_pkg;

	typedef enum logic [2:0] {
		SUT_IDLE  = 3'b000,
		SUT_START = 3'b001,
		SUT_DATA  = 3'b010,
		SUT_BRK   = 3'b011,
		SUT_STOP  = 3'b100
	} sut_state_t;

	typedef struct packed {
		logic       word_len_select;
		logic       parity_enable;
		logic       parity_type;
		logic       stop_count;
		logic       ninth_tx_bit;
	} sut_format_t;

	typedef struct packed {
		logic       tx_out;
		logic       tx_oe_n;
	} sut_pin_t;

endpackage : sut_pkg

/* hw/sut_uart_tx.sv */
// Purpose: Serial unit frame formatting and transmitter with Avalon-MM register access
// Assumes: 10 MHz mclk, synchronous active-high rst
// Notes:   Receiver path reduced to the flags that disabling touches
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "sut_defs.svh"

module sut_uart_tx
	import sut_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Serial pins
	output sut_pin_t         tx_pin,
	output logic             rx_oe_n,
	// Interrupt request
	output logic             tx_empty_irq
);

	// ============================================================
	// Registers
	logic [7:0]  serial_ctrl_reg1;
	logic [7:0]  serial_ctrl_reg2;
	logic [7:0]  baud_divisor;
	logic [7:0]  serial_status_reg;
	logic [8:0]  tx_holding;
	logic        hold_full;
	logic [10:0] tx_shifter;
	logic [3:0]  bits_left;
	logic [3:0]  brk_cnt;
	logic        stop_left;
	logic        status_seen;
	logic        ack_done;
	logic [7:0]  pre_cnt;
	logic [7:0]  div_cnt;
	logic        shift_en;
	sut_state_t  state;
	sut_format_t fmt;

	logic        unit_en;
	logic        tx_en;
	logic        acc;
	logic        wr_ctrl1;
	logic        wr_ctrl2;
	logic        wr_data;
	logic        data_ok;
	logic        load_now;
	logic        frame_end;
	logic        parity_bit;
	logic [8:0]  frame_src;
	logic [10:0] next_shifter;
	logic [3:0]  next_bits;
	logic        tx_bit;
	logic        tx_off;

	assign unit_en  = serial_ctrl_reg1[`SUT_C1_UNIT_EN];
	assign tx_en    = serial_ctrl_reg2[`SUT_C2_TX_EN];
	assign fmt      = '{serial_ctrl_reg1[`SUT_C1_WORD_LEN], serial_ctrl_reg1[`SUT_C1_PAR_EN],
		serial_ctrl_reg1[`SUT_C1_PAR_TYPE], serial_ctrl_reg1[`SUT_C1_STOP_CNT],
		serial_ctrl_reg1[`SUT_C1_NINTH_TX]};
	assign acc      = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_ctrl1 = acc & avs_write & (avs_address == `SUT_ADDR_CTRL1);
	assign wr_ctrl2 = acc & avs_write & (avs_address == `SUT_ADDR_CTRL2);
	assign wr_data  = acc & avs_write & (avs_address == `SUT_ADDR_TXDATA);
	// Data accepted only with empty flag set and after a status access
	assign data_ok  = wr_data & unit_en & serial_status_reg[`SUT_ST_TX_EMPTY] & status_seen;

	// ============================================================
	// Bus slave: one wait cycle per access, read data registered
	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read | avs_write) & avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & avs_waitrequest) begin
			case (avs_address)
				`SUT_ADDR_CTRL1:  avs_readdata <= {24'h0, serial_ctrl_reg1};
				`SUT_ADDR_CTRL2:  avs_readdata <= {24'h0, serial_ctrl_reg2};
				`SUT_ADDR_DIV:    avs_readdata <= {24'h0, baud_divisor};
				`SUT_ADDR_STATUS: avs_readdata <= {24'h0, serial_status_reg};
				default:          avs_readdata <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_seen <= 1'b0;
		end else if (acc & (avs_address == `SUT_ADDR_STATUS)) begin
			status_seen <= 1'b1;
		end else if (wr_data | ~unit_en) begin
			status_seen <= 1'b0;
		end
	end

	// ============================================================
	// Control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			serial_ctrl_reg1 <= `SUT_C1_RESET;
		end else if (wr_ctrl1) begin
			serial_ctrl_reg1 <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			serial_ctrl_reg2 <= `SUT_C2_RESET;
		end else if (!unit_en) begin
			// Enables and break cleared, speed and irq enable kept
			serial_ctrl_reg2[`SUT_C2_TX_EN] <= 1'b0;
			serial_ctrl_reg2[`SUT_C2_RX_EN] <= 1'b0;
			serial_ctrl_reg2[`SUT_C2_BREAK] <= 1'b0;
			if (wr_ctrl2) begin
				serial_ctrl_reg2[`SUT_C2_BAUD_HI] <= avs_writedata[`SUT_C2_BAUD_HI];
				serial_ctrl_reg2[`SUT_C2_ADDR_EN] <= avs_writedata[`SUT_C2_ADDR_EN];
				serial_ctrl_reg2[`SUT_C2_TX_EMPTY_IRQ_ENABLE]    <= avs_writedata[`SUT_C2_TX_EMPTY_IRQ_ENABLE];
			end
		end else if (wr_ctrl2) begin
			serial_ctrl_reg2 <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			baud_divisor <= `SUT_DIV_RESET;
		end else if (acc & avs_write & (avs_address == `SUT_ADDR_DIV)) begin
			baud_divisor <= avs_writedata[7:0];
		end
	end

	// ============================================================
	// Baud generator: prescale 64 or 16, then divide by N+1
	always_ff @(posedge mclk) begin
		if (rst | ~unit_en) begin
			pre_cnt  <= 8'h00;
			div_cnt  <= 8'h00;
			shift_en <= 1'b0;
		end else begin
			shift_en <= 1'b0;
			if (pre_cnt >= (serial_ctrl_reg2[`SUT_C2_BAUD_HI] ? `SUT_PRE_HIGH : `SUT_PRE_LOW)) begin
				pre_cnt <= 8'h00;
				if (div_cnt >= baud_divisor) begin
					div_cnt  <= 8'h00;
					shift_en <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 8'h01;
				end
			end else begin
				pre_cnt <= pre_cnt + 8'h01;
			end
		end
	end

	// ============================================================
	// Frame assembly: parity in last data slot, ninth bit from control
	always_comb begin
		frame_src = hold_full ? tx_holding : 9'h000;
		if (fmt.word_len_select) begin
			frame_src[8] = fmt.ninth_tx_bit;
		end else begin
			frame_src[8] = 1'b0;
		end
		parity_bit = fmt.parity_type ^ (fmt.word_len_select ? ^frame_src[7:0] : ^frame_src[6:0]);
		if (fmt.parity_enable) begin
			if (fmt.word_len_select) begin
				frame_src[8] = parity_bit;
			end else begin
				frame_src[7] = parity_bit;
			end
		end
		next_bits    = fmt.word_len_select ? 4'h9 : 4'h8;
		next_shifter = {2'b11, frame_src};
	end

	// Load when idle with data or break, enabled and at a bit boundary
	assign load_now  = (state == SUT_IDLE) & tx_en & shift_en
		& (hold_full | serial_ctrl_reg2[`SUT_C2_BREAK]);
	assign frame_end = (state == SUT_STOP) & shift_en & ~stop_left;

	// ============================================================
	// Transmit state machine
	always_ff @(posedge mclk) begin
		if (rst | ~unit_en | ~tx_en) begin
			state      <= SUT_IDLE;
			tx_shifter <= 11'h7ff;
			bits_left  <= 4'h0;
			brk_cnt    <= 4'h0;
			stop_left  <= 1'b0;
			tx_bit     <= 1'b1;
		end else if (shift_en) begin
			case (state)
				SUT_IDLE: begin
					tx_bit        <= 1'b1;
					if (load_now) begin
						tx_bit        <= 1'b0;
						tx_shifter    <= next_shifter;
						bits_left     <= next_bits;
						brk_cnt       <= `SUT_BREAK_BITS;
						state         <= serial_ctrl_reg2[`SUT_C2_BREAK] ? SUT_BRK : SUT_START;
					end
				end
				SUT_START: begin
					tx_bit        <= tx_shifter[0];
					tx_shifter    <= {1'b1, tx_shifter[10:1]};
					bits_left     <= bits_left - 4'h1;
					state         <= SUT_DATA;
				end
				SUT_DATA: begin
					if (bits_left == 4'h0) begin
						tx_bit        <= 1'b1;
						stop_left     <= fmt.stop_count;
						state         <= SUT_STOP;
					end else begin
						tx_bit        <= tx_shifter[0];
						tx_shifter    <= {1'b1, tx_shifter[10:1]};
						bits_left     <= bits_left - 4'h1;
					end
				end
				SUT_BRK: begin
					if (brk_cnt == 4'h0) begin
						if (serial_ctrl_reg2[`SUT_C2_BREAK]) begin
							tx_bit        <= 1'b0;
							brk_cnt       <= `SUT_BREAK_BITS - 4'h1;
						end else begin
							tx_bit        <= 1'b1;
							stop_left     <= fmt.stop_count;
							state         <= SUT_STOP;
						end
					end else begin
						tx_bit        <= 1'b0;
						brk_cnt       <= brk_cnt - 4'h1;
					end
				end
				SUT_STOP: begin
					tx_bit        <= 1'b1;
					if (stop_left) begin
						stop_left <= 1'b0;
					end else begin
						state <= SUT_IDLE;
					end
				end
				default: state <= SUT_IDLE;
			endcase
		end
	end

	// Pins float while unit or transmitter is off
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_off  <= 1'b1;
			rx_oe_n <= 1'b1;
		end else begin
			tx_off  <= ~(unit_en & tx_en);
			rx_oe_n <= 1'b1;
		end
	end
	assign tx_pin = '{tx_out: tx_bit, tx_oe_n: tx_off};

	// ============================================================
	// Holding register
	always_ff @(posedge mclk) begin
		if (rst | ~unit_en) begin
			hold_full  <= 1'b0;
			tx_holding <= 9'h000;
		end else if (data_ok) begin
			hold_full  <= 1'b1;
			tx_holding <= {1'b0, avs_writedata[7:0]};
		end else if (load_now & ~serial_ctrl_reg2[`SUT_C2_BREAK]) begin
			hold_full <= 1'b0;
		end
	end

	// ============================================================
	// Status flags: set by hardware wins over the write-sequence clear
	always_ff @(posedge mclk) begin
		if (rst | ~unit_en) begin
			serial_status_reg <= 8'h00;
			serial_status_reg[`SUT_ST_TX_EMPTY] <= 1'b1;
			serial_status_reg[`SUT_ST_TX_DONE]  <= 1'b1;
			serial_status_reg[`SUT_ST_RX_QUIET] <= 1'b1;
		end else begin
			if (load_now & ~serial_ctrl_reg2[`SUT_C2_BREAK]) begin
				serial_status_reg[`SUT_ST_TX_EMPTY] <= 1'b1;
			end else if (data_ok) begin
				serial_status_reg[`SUT_ST_TX_EMPTY] <= 1'b0;
			end
			if (frame_end) begin
				serial_status_reg[`SUT_ST_TX_DONE] <= 1'b1;
			end else if (ack_done) begin
				serial_status_reg[`SUT_ST_TX_DONE] <= 1'b0;
			end
		end
	end
	assign ack_done = wr_data & unit_en & status_seen;
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_empty_irq <= 1'b0;
		end else begin
			tx_empty_irq <= serial_ctrl_reg2[`SUT_C2_TX_EMPTY_IRQ_ENABLE] & serial_status_reg[`SUT_ST_TX_EMPTY];
		end
	end

	// ============================================================
	// Checks
	property p_idle_high;
		@(posedge mclk) disable iff (rst)
		(state == SUT_IDLE) & unit_en & tx_en & ~load_now & shift_en |=> tx_pin.tx_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not high when idle");
	property p_float_off;
		@(posedge mclk) disable iff (rst)
		~unit_en |=> tx_pin.tx_oe_n & rx_oe_n;
	endproperty
	a_float_off: assert property (p_float_off) else $error("pins driven while disabled");
	property p_flush;
		@(posedge mclk) disable iff (rst)
		~unit_en |=> ~hold_full & (state == SUT_IDLE);
	endproperty
	a_flush: assert property (p_flush) else $error("buffer not flushed");
	property p_dis_flags;
		@(posedge mclk) disable iff (rst)
		~unit_en |=> serial_status_reg[`SUT_ST_TX_EMPTY] & serial_status_reg[`SUT_ST_TX_DONE]
			& ~serial_ctrl_reg2[`SUT_C2_TX_EN];
	endproperty
	a_dis_flags: assert property (p_dis_flags) else $error("disable flags wrong");
	property p_block_write;
		@(posedge mclk) disable iff (rst)
		wr_data & ~serial_status_reg[`SUT_ST_TX_EMPTY] & ~load_now |=> $stable(tx_holding);
	endproperty
	a_block_write: assert property (p_block_write) else $error("holding overwritten");
	sequence s_start_bit;
		shift_en & load_now & unit_en;
	endsequence
	property p_start;
		@(posedge mclk) disable iff (rst)
		s_start_bit |=> ~tx_pin.tx_out;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_done;
		@(posedge mclk) disable iff (rst)
		frame_end & unit_en & tx_en |=> serial_status_reg[`SUT_ST_TX_DONE];
	endproperty
	a_done: assert property (p_done) else $error("complete flag missed");
	property p_txoff;
		@(posedge mclk) disable iff (rst)
		unit_en & $fell(tx_en) |-> ##1 (state == SUT_IDLE) ##0 tx_pin.tx_oe_n;
	endproperty
	a_txoff: assert property (p_txoff) else $error("tx disable not immediate");
	property p_baud;
		@(posedge mclk) disable iff (rst)
		shift_en |=> ~shift_en [*8];
	endproperty
	a_baud: assert property (p_baud) else $error("shift enable too frequent");
endmodule : sut_uart_tx

/* testbench/sut_peer.sv */
// Purpose: Remote serial receiver that decodes frames seen on the transmit line
// Assumes: Line pulled high when released; bit length given in clocks
// Notes:   Samples each bit in its middle
`timescale 1ns/1ps

module sut_peer (
	// Clock
	input  wire logic        mclk,
	// Serial line and frame shape
	input  wire logic        line,
	input  wire logic [15:0] bit_clks,
	input  wire logic [3:0]  nbits,
	input  wire logic [1:0]  nstop,
	// Decoded frame
	output logic      [8:0]  word,
	output logic             stop_ok,
	output logic             stb
);
	logic [8:0] w;
	logic       ok;

	// ============================================================
	// Frame decoder
	initial begin
		stb = 1'b0;
		word = 9'h000;
		stop_ok = 1'b0;
		forever begin
			@(negedge line);
			repeat (bit_clks / 2) @(posedge mclk);
			if (line === 1'b0) begin
				w = 9'h000;
				ok = 1'b1;
				for (int i = 0; i < nbits; i++) begin
					repeat (bit_clks) @(posedge mclk);
					w[i] = line;
				end
				for (int s = 0; s < nstop; s++) begin
					repeat (bit_clks) @(posedge mclk);
					ok = ok & (line === 1'b1);
				end
				word <= w;
				stop_ok <= ok;
				stb <= 1'b1;
				@(posedge mclk);
				stb <= 1'b0;
			end
		end
	end
endmodule : sut_peer

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the serial transmitter over Avalon-MM
// Assumes: Transmit pin has a pull-up when released
// Notes:   Frames are decoded by the peer and compared with a bench model
`timescale 1ns/1ps
`include "sut_defs.svh"

module testbench
	import sut_pkg::*;
;
	logic        mclk;
	logic        rst;
	logic [2:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	sut_pin_t    tx_pin;
	logic        rx_oe_n;
	logic        tx_empty_irq;
	logic [15:0] bit_clks;
	logic [3:0]  nbits;
	logic [1:0]  nstop;
	logic [8:0]  p_word;
	logic        p_ok;
	logic        p_stb;
	logic [8:0]  rxq[$];
	logic        okq[$];
	logic [7:0]  q;
	logic [7:0]  d;
	int          miscompares;
	int          compares;
	int          n;
	wire         line = tx_pin.tx_oe_n ? 1'b1 : tx_pin.tx_out;

	sut_uart_tx dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tx_pin(tx_pin), .rx_oe_n(rx_oe_n),
		.tx_empty_irq(tx_empty_irq));
	sut_peer peer (.mclk(mclk), .line(line), .bit_clks(bit_clks), .nbits(nbits),
		.nstop(nstop), .word(p_word), .stop_ok(p_ok), .stb(p_stb));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (p_stb === 1'b1) begin
			rxq.push_back(p_word);
			okq.push_back(p_ok);
		end
	end

	// ============================================================
	// Report and compare
	task automatic summarize;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	task automatic hang;
		miscompares++;
		$display("FAIL t=%0t wait limit got=%h exp=%h", $time, 1'b0, 1'b1);
		summarize;
	endtask : hang

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t reg got=%h exp=%h", $time, g, e);
		end
	endtask : chk8

	task automatic chk9(input logic [8:0] g, input logic [8:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t word got=%h exp=%h", $time, g, e);
		end
	endtask : chk9

	task automatic chk1(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t bit got=%h exp=%h", $time, g, e);
		end
	endtask : chk1

	// ============================================================
	// Bus access and waits
	task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h000000, wd};
		do begin
			@(posedge mclk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			hang;
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic send(input logic [7:0] v);
		int k;
		k = 0;
		do begin
			bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
			k++;
		end while (q[`SUT_ST_TX_EMPTY] !== 1'b1 && k < 200);
		if (k >= 200)
			hang;
		bus(`SUT_ADDR_TXDATA, 1'b1, v);
	endtask : send

	task automatic wait_frames(input int cnt);
		int k;
		k = 0;
		while (rxq.size() < cnt && k < 20000) begin
			@(posedge mclk);
			k++;
		end
		if (k >= 20000)
			hang;
	endtask : wait_frames

	task automatic low_run(output int r);
		int k;
		k = 0;
		r = 0;
		while (line !== 1'b0 && k < 5000) begin
			@(posedge mclk);
			k++;
		end
		while (line === 1'b0 && r < 20000) begin
			@(posedge mclk);
			r++;
		end
		if (k >= 5000)
			hang;
	endtask : low_run

	task automatic flush;
		repeat (20 * bit_clks) @(posedge mclk);
		rxq.delete();
		okq.delete();
	endtask : flush

	// Expected data field; f = {word_len, par_en, par_type, stop_count, ninth}
	function automatic logic [8:0] model(input logic [7:0] v, input logic [4:0] f);
		logic [8:0] w;
		logic       p;
		w = {f[4] & f[0], v};
		p = (f[4] ? ^v : ^v[6:0]) ^ f[2];
		if (f[3] && f[4])
			w[8] = p;
		else if (f[3])
			w[7] = p;
		return w;
	endfunction : model

	// ============================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		bit_clks = 16'h0010;
		nbits = 4'h8;
		nstop = 2'h1;
		miscompares = 0;
		compares = 0;
		void'($urandom(32'h55c7));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		bus(3'h5, 1'b1, 8'hff);
		for (int a = 0; a < 8; a++) begin
			bus(a[2:0], 1'b0, 8'h00);
			chk8(q, (a == `SUT_ADDR_STATUS) ? 8'h0b : 8'h00);
		end
		chk1(tx_pin.tx_oe_n, 1'b1);
		chk1(rx_oe_n, 1'b1);
		bus(`SUT_ADDR_CTRL1, 1'b1, 8'h80);
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'he1);
		repeat (2) @(posedge mclk);
		chk1(tx_pin.tx_oe_n, 1'b0);
		chk1(tx_pin.tx_out, 1'b1);
		for (int f = 0; f < 32; f++) begin
			d = 8'($urandom);
			nbits = 4'h8 + f[4];
			nstop = 2'h1 + f[1];
			bus(`SUT_ADDR_CTRL1, 1'b1, {1'b1, f[4:0], 2'b00});
			send(d);
			wait_frames(1);
			chk9(rxq.pop_front(), model(d, f[4:0]));
			chk1(okq.pop_front(), 1'b1);
			repeat (bit_clks * 2) @(posedge mclk);
			bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
			chk1(q[`SUT_ST_TX_DONE], 1'b1);
			chk1(tx_empty_irq, 1'b1);
		end
		nbits = 4'h8;
		nstop = 2'h1;
		bus(`SUT_ADDR_CTRL1, 1'b1, 8'h80);
		send(8'ha5);
		bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
		chk1(q[`SUT_ST_TX_DONE], 1'b0);
		send(8'h3c);
		bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
		chk1(q[`SUT_ST_TX_EMPTY], 1'b0);
		chk1(tx_empty_irq, 1'b0);
		bus(`SUT_ADDR_TXDATA, 1'b1, 8'h99);
		wait_frames(2);
		chk9(rxq.pop_front(), 9'h0a5);
		chk9(rxq.pop_front(), 9'h03c);
		repeat (bit_clks * 30) @(posedge mclk);
		chk1(rxq.size() == 0, 1'b1);
		bus(`SUT_ADDR_TXDATA, 1'b1, 8'h77);
		bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
		chk1(q[`SUT_ST_TX_EMPTY], 1'b1);
		send(8'h55);
		repeat (60) @(posedge mclk);
		bus(`SUT_ADDR_CTRL1, 1'b1, 8'h48);
		repeat (2) @(posedge mclk);
		chk1(tx_pin.tx_oe_n, 1'b1);
		bus(`SUT_ADDR_STATUS, 1'b0, 8'h00);
		chk8(q, 8'h0b);
		bus(`SUT_ADDR_CTRL2, 1'b0, 8'h00);
		chk8(q, 8'h21);
		flush;
		nbits = 4'h9;
		nstop = 2'h2;
		bus(`SUT_ADDR_CTRL1, 1'b1, 8'hc8);
		d = 8'($urandom);
		send(d);
		repeat (bit_clks * 2) @(posedge mclk);
		chk1(tx_pin.tx_oe_n, 1'b1);
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'he1);
		wait_frames(1);
		chk9(rxq.pop_front(), model(d, 5'b10010));
		okq.delete();
		send(8'h0f);
		repeat (60) @(posedge mclk);
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'h61);
		repeat (2) @(posedge mclk);
		chk1(tx_pin.tx_oe_n, 1'b1);
		flush;
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'he1);
		d = 8'($urandom);
		send(d);
		wait_frames(1);
		chk9(rxq.pop_front(), {1'b0, d});
		nbits = 4'h8;
		nstop = 2'h1;
		bus(`SUT_ADDR_CTRL1, 1'b1, 8'h80);
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'hf1);
		fork
			begin
				repeat (300) @(posedge mclk);
				bus(`SUT_ADDR_CTRL2, 1'b1, 8'he1);
			end
		join_none
		low_run(n);
		chk1(n % 16 == 0 && n >= 224 && (n / 16 - 1) % 13 == 0, 1'b1);
		flush;
		bit_clks = 16'h0080;
		bus(`SUT_ADDR_DIV, 1'b1, 8'h01);
		bus(`SUT_ADDR_CTRL2, 1'b1, 8'hc1);
		send(8'hff);
		low_run(n);
		chk9(n[8:0], 9'h080);
		wait_frames(1);
		chk9(rxq.pop_front(), 9'h0ff);
		summarize;
	end
endmodule : testbench
